//--- hw/tws_defs.vh
// Constants shared by the two-wire register slave files.
// Assumes inclusion by bare name from files under hw/.
`ifndef TWS_DEFS_VH
`define TWS_DEFS_VH

// Slave address byte (write form) chosen by the address select pin
`define TWS_ADDR_PIN_LOW 8'h90
`define TWS_ADDR_PIN_HIGH 8'hba

// Address byte layout
`define TWS_ADDR_MSB 7
`define TWS_ADDR_LSB 1
`define TWS_DIR_BIT 0
`define TWS_DIR_READ 1'b1

// Bits per byte on the wire, before the acknowledge slot
`define TWS_BYTE_BITS 4'h8

// Register byte pointer after reset
`define TWS_PTR_RESET 16'h0000
`define TWS_PTR_STEP 16'h0001

// Write byte phases after the address byte
`define TWS_PHASE_ADDR_HI 2'h0
`define TWS_PHASE_ADDR_LO 2'h1
`define TWS_PHASE_DATA 2'h2

// Idle level of the bus lines, loaded into the edge detector's previous samples under reset
`define TWS_LINE_IDLE 1'b1

`endif

//--- hw/tws_sync.v
// Three-flop synchroniser for inputs from outside the clock domain.
// Assumes the inputs may change at any time; output follows once
// the second and third stage agree.
`timescale 1ns/1ps

module tws_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
    input wire clock,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] clean
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;
reg [WIDTH-1:0] stage3;
integer i;

always @(posedge clock) begin
    if (rst) begin
        stage1 <= INIT;
        stage2 <= INIT;
        stage3 <= INIT;
        clean <= INIT;
    end else begin
        stage1 <= async_in;
        stage2 <= stage1;
        stage3 <= stage2;
        // Two agreeing samples filter a single-cycle glitch
        for (i = 0; i < WIDTH; i = i + 1) begin
            if (stage2[i] == stage3[i]) begin
                clean[i] <= stage3[i];
            end
        end
    end
end

endmodule // tws_sync

//--- hw/tws_edge.v
// Bus condition detector: start, stop and serial clock edges.
// Assumes both lines arrive already synchronised to clock.
`timescale 1ns/1ps
`include "tws_defs.vh"

module tws_edge (
    input wire clock,
    input wire rst,
    input wire scl,
    input wire sda,
    output wire start_seen,
    output wire stop_seen,
    output wire scl_rise,
    output wire scl_fall
);

reg scl_prev;
reg sda_prev;

always @(posedge clock) begin
    if (rst) begin
        scl_prev <= `TWS_LINE_IDLE;
        sda_prev <= `TWS_LINE_IDLE;
    end else begin
        scl_prev <= scl;
        sda_prev <= sda;
    end
end

// Data falling with the clock high both before and after
assign start_seen = scl & scl_prev & sda_prev & ~sda;
// Data rising with the clock high
assign stop_seen = scl & scl_prev & ~sda_prev & sda;
assign scl_rise = scl & ~scl_prev;
assign scl_fall = ~scl & scl_prev;

endmodule // tws_edge

//--- hw/tws_slave.v
// Two-wire serial slave giving a bus master access to the registers.
// Assumes the master drives the serial clock (no stretching here) and
// that the register file answers reg_rdata in the cycle of reg_rd.
// Limitation: the data line answers about five clocks after the serial
// clock pin falls, so the master's low phase must last six clocks.
//
// Notes on behaviour
// - Address 0x90 with pin low, 0xBA high.
// - Override input replaces pin-selected slave address.
// - Start: data falls while clock high.
// - Start without stop is a repeated start.
// - Bytes are eight bits, MSB first, plus ack.
// - Data changes only while clock is low.
// - Bits 7..1 address, bit 0 direction.
// - Transmitter releases, receiver pulls ack low.
// - Undriven ack slot is a no-acknowledge.
// - Stop: data rises while clock high.
// - Acknowledge address byte only on match.
// - Two register address bytes follow write address.
// - Any number of data bytes, each acknowledged.
// - Read without address uses retained pointer.
// - Single random read returns one byte.
// - Keep sending while master acknowledges.
// - Keep accepting write bytes until stop.
`timescale 1ns/1ps
`include "tws_defs.vh"

module tws_slave (
    input wire clock,
    input wire rst,
    input wire serial_clock_line_in,
    input wire serial_data_line_in,
    output reg serial_data_line_out,
    output reg serial_data_line_oe,
    input wire address_select_pin,
    input wire addr_override_en,
    input wire [7:0] addr_override,
    output reg [15:0] reg_addr,
    output reg [7:0] reg_wdata,
    output reg reg_wr,
    output reg reg_rd,
    input wire [7:0] reg_rdata,
    output reg bus_busy,
    output reg selected,
    output reg read_mode
);

localparam [6:0] S_IDLE = 7'h01;
localparam [6:0] S_ADDR = 7'h02;
localparam [6:0] S_ACK = 7'h04;
localparam [6:0] S_RX = 7'h08;
localparam [6:0] S_TX = 7'h10;
localparam [6:0] S_TXACK = 7'h20;
localparam [6:0] S_IGNORE = 7'h40;

reg [6:0] state;
reg [3:0] bit_cnt;
reg [7:0] rx_shift;
reg [7:0] tx_shift;
reg [1:0] wr_phase;
reg master_ack;
reg [7:0] own_addr;

wire scl;
wire sda;
wire pin_sel;
wire start_seen;
wire stop_seen;
wire scl_rise;
wire scl_fall;

// Pin straps and override feed the address compare
function [7:0] pick_address;
    input pin;
    input ovr_en;
    input [7:0] ovr;
    begin
        if (ovr_en) begin
            pick_address = ovr;
        end else if (pin) begin
            pick_address = `TWS_ADDR_PIN_HIGH;
        end else begin
            pick_address = `TWS_ADDR_PIN_LOW;
        end
    end
endfunction

// Open-drain: a one on the wire is released, a zero is pulled low
function drive_low;
    input bit_value;
    begin
        drive_low = ~bit_value;
    end
endfunction

// Sampled bit enters at the bottom, first bit ends up as the MSB
function [7:0] shift_in;
    input [7:0] cur;
    input bit_in;
    begin
        shift_in = {cur[6:0], bit_in};
    end
endfunction

// MSB leaves first; the zero fill never reaches the wire
function [7:0] shift_out;
    input [7:0] cur;
    begin
        shift_out = {cur[6:0], 1'b0};
    end
endfunction

function [3:0] count_up;
    input [3:0] count;
    begin
        count_up = count + 4'h1;
    end
endfunction

// A byte closes on the fall that ends its eighth bit period
function byte_over;
    input fall;
    input [3:0] count;
    begin
        byte_over = fall && (count == `TWS_BYTE_BITS);
    end
endfunction

// Bit 0 is the direction and takes no part in the compare
function addr_match;
    input [7:0] rx;
    input [7:0] own;
    begin
        addr_match = (rx[`TWS_ADDR_MSB:`TWS_ADDR_LSB] == own[`TWS_ADDR_MSB:`TWS_ADDR_LSB]);
    end
endfunction

function dir_is_read;
    input [7:0] rx;
    begin
        dir_is_read = (rx[`TWS_DIR_BIT] == `TWS_DIR_READ);
    end
endfunction

tws_sync #(
    .WIDTH(3),
    .INIT(3'h3)
) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in({address_select_pin, serial_clock_line_in, serial_data_line_in}),
    .clean({pin_sel, scl, sda})
);

tws_edge u_edge (
    .clock(clock),
    .rst(rst),
    .scl(scl),
    .sda(sda),
    .start_seen(start_seen),
    .stop_seen(stop_seen),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall)
);

// Address follows the pin continuously; a change mid-frame only
// matters at the next address byte
always @(posedge clock) begin
    if (rst) begin
        own_addr <= `TWS_ADDR_PIN_LOW;
    end else begin
        own_addr <= pick_address(pin_sel, addr_override_en, addr_override);
    end
end

always @(posedge clock) begin
    if (rst) begin
        state <= S_IDLE;
        bit_cnt <= 4'h0;
        rx_shift <= 8'h00;
        tx_shift <= 8'h00;
        wr_phase <= `TWS_PHASE_ADDR_HI;
        master_ack <= 1'b0;
        serial_data_line_out <= 1'b0;
        serial_data_line_oe <= 1'b0;
        reg_addr <= `TWS_PTR_RESET;
        reg_wdata <= 8'h00;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        bus_busy <= 1'b0;
        selected <= 1'b0;
        read_mode <= 1'b0;
    end else begin
        // The pin is only ever pulled low; release lets it float high
        serial_data_line_out <= 1'b0;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;

        // Pointer moves after each data byte moved either way
        if (reg_wr || reg_rd) begin
            reg_addr <= reg_addr + `TWS_PTR_STEP;
        end
        // Read data is captured before the fall that drives its first bit
        if (reg_rd) begin
            tx_shift <= reg_rdata;
        end

        if (start_seen) begin
            // Start or restart ends whatever was going on
            state <= S_ADDR;
            bit_cnt <= 4'h0;
            wr_phase <= `TWS_PHASE_ADDR_HI;
            serial_data_line_oe <= 1'b0;
            bus_busy <= 1'b1;
            selected <= 1'b0;
        end else if (stop_seen) begin
            state <= S_IDLE;
            serial_data_line_oe <= 1'b0;
            bus_busy <= 1'b0;
            selected <= 1'b0;
        end else begin
            case (state)
                S_ADDR: begin
                    if (scl_rise) begin
                        // Sampled on the rise, data held stable while high
                        rx_shift <= shift_in(rx_shift, sda);
                        bit_cnt <= count_up(bit_cnt);
                    end else if (byte_over(scl_fall, bit_cnt)) begin
                        bit_cnt <= 4'h0;
                        if (addr_match(rx_shift, own_addr)) begin
                            serial_data_line_oe <= 1'b1;
                            state <= S_ACK;
                            selected <= 1'b1;
                            read_mode <= dir_is_read(rx_shift);
                            // Fetch first byte at the retained pointer
                            reg_rd <= dir_is_read(rx_shift);
                        end else begin
                            state <= S_IGNORE;
                        end
                    end
                end

                S_ACK: begin
                    // Ack held through the whole clock period
                    if (scl_fall) begin
                        if (read_mode) begin
                            state <= S_TX;
                            serial_data_line_oe <= drive_low(tx_shift[7]);
                            tx_shift <= shift_out(tx_shift);
                            bit_cnt <= 4'h1;
                        end else begin
                            state <= S_RX;
                            serial_data_line_oe <= 1'b0;
                            bit_cnt <= 4'h0;
                        end
                    end
                end

                S_RX: begin
                    if (scl_rise) begin
                        rx_shift <= shift_in(rx_shift, sda);
                        bit_cnt <= count_up(bit_cnt);
                    end else if (byte_over(scl_fall, bit_cnt)) begin
                        // Every received byte is acknowledged
                        serial_data_line_oe <= 1'b1;
                        state <= S_ACK;
                        bit_cnt <= 4'h0;
                        case (wr_phase)
                            `TWS_PHASE_ADDR_HI: begin
                                reg_addr[15:8] <= rx_shift;
                                wr_phase <= `TWS_PHASE_ADDR_LO;
                            end
                            `TWS_PHASE_ADDR_LO: begin
                                reg_addr[7:0] <= rx_shift;
                                wr_phase <= `TWS_PHASE_DATA;
                            end
                            default: begin
                                // Any number of data bytes, one register byte each
                                reg_wdata <= rx_shift;
                                reg_wr <= 1'b1;
                                wr_phase <= `TWS_PHASE_DATA;
                            end
                        endcase
                    end
                end

                S_TX: begin
                    if (scl_fall) begin
                        if (byte_over(scl_fall, bit_cnt)) begin
                            // Transmitter lets go for the master's answer
                            serial_data_line_oe <= 1'b0;
                            state <= S_TXACK;
                            bit_cnt <= 4'h0;
                        end else begin
                            serial_data_line_oe <= drive_low(tx_shift[7]);
                            tx_shift <= shift_out(tx_shift);
                            bit_cnt <= count_up(bit_cnt);
                        end
                    end
                end

                S_TXACK: begin
                    if (scl_rise) begin
                        master_ack <= ~sda;
                        // Prefetch only when another byte is wanted, so the
                        // pointer ends just past the last byte read
                        reg_rd <= ~sda;
                    end else if (scl_fall) begin
                        if (master_ack) begin
                            state <= S_TX;
                            serial_data_line_oe <= drive_low(tx_shift[7]);
                            tx_shift <= shift_out(tx_shift);
                            bit_cnt <= 4'h1;
                        end else begin
                            // No-acknowledge ends the read; wait for stop or restart
                            state <= S_IGNORE;
                            serial_data_line_oe <= 1'b0;
                        end
                    end
                end

                S_IGNORE: begin
                    serial_data_line_oe <= 1'b0;
                end

                S_IDLE: begin
                    serial_data_line_oe <= 1'b0;
                end

                default: begin
                    state <= S_IDLE;
                    serial_data_line_oe <= 1'b0;
                end
            endcase
        end
    end
end

endmodule // tws_slave

//--- sim/tws_slave_properties.sv
// Port checker for the two-wire register slave.
// Assumes binding to tws_slave; rising clock, synchronous active-high rst.
`timescale 1ns/1ps
module tws_slave_properties (
    input wire clock,
    input wire rst,
    input wire serial_clock_line_in,
    input wire serial_data_line_in,
    input wire serial_data_line_out,
    input wire serial_data_line_oe,
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire bus_busy,
    input wire selected,
    input wire read_mode
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    AST_OUT_LOW: assert property (serial_data_line_out == 1'b0) else $error("data out not low");
    AST_WR_PULSE: assert property (reg_wr |=> !reg_wr) else $error("write pulse too long");
    AST_WR_STEP: assert property (reg_wr |=> reg_addr == $past(reg_addr) + 16'h0001)
        else $error("pointer not advanced after write");
    AST_RD_STEP: assert property (reg_rd |=> reg_addr == $past(reg_addr) + 16'h0001)
        else $error("pointer not advanced after read");
    AST_WR_DIR: assert property (reg_wr |-> selected && !read_mode) else $error("write outside write");
    AST_RD_DIR: assert property (reg_rd |-> selected && read_mode) else $error("read outside read");
    AST_IDLE_FREE: assert property (!bus_busy |-> !serial_data_line_oe) else $error("line held when idle");
    AST_START_BUSY: assert property (($fell(serial_data_line_in) && serial_clock_line_in)
        |-> ##[1:8] bus_busy) else $error("start not seen");
    AST_STOP_IDLE: assert property (($rose(serial_data_line_in) && serial_clock_line_in
        && !$past(serial_data_line_oe)) |-> ##[1:8] !bus_busy) else $error("stop not seen");
    cover property (reg_wr);
    cover property (reg_rd);
    cover property (read_mode && bus_busy);
endmodule // tws_slave_properties

bind tws_slave tws_slave_properties u_props (.clock(clock), .rst(rst),
    .serial_clock_line_in(serial_clock_line_in), .serial_data_line_in(serial_data_line_in),
    .serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .bus_busy(bus_busy),
    .selected(selected), .read_mode(read_mode));

//--- sim/tws_host_model.sv
// Bus master model: drives the serial clock and pulls the data line low.
// Assumes a pull-up on the data line; paced by falling edges of clock.
`timescale 1ns/1ps
module tws_host_model (
    input wire clock,
    input wire sda_line,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask
    task start_cond;
        sda_low = 1'b1;
        wait_n(4);
        scl = 1'b0;
    endtask
    task restart_cond;
        wait_n(3);
        sda_low = 1'b0;
        wait_n(3);
        scl = 1'b1;
        wait_n(4);
        start_cond;
    endtask
    task stop_cond;
        wait_n(3);
        sda_low = 1'b1;
        wait_n(3);
        scl = 1'b1;
        wait_n(4);
        sda_low = 1'b0;
        wait_n(8);
    endtask
    // Low six clocks, high two: the slave answers about five clocks
    // after a fall, so its data settles before the rise
    task bit_xfer(input logic b, output logic r);
        wait_n(3);
        sda_low = !b;
        wait_n(3);
        scl = 1'b1;
        wait_n(2);
        r = sda_line;
        scl = 1'b0;
    endtask
    task wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(b[i], r);
        bit_xfer(1'b1, r);
        ack = !r;
    endtask
    task rd_byte(input logic ack_it, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_xfer(1'b1, r);
            d = {d[6:0], r};
        end
        bit_xfer(!ack_it, r);
    endtask
endmodule // tws_host_model

//--- sim/tws_slave_tb_top.sv
// Self-checking bench for the two-wire register slave.
// Assumes tws_slave, the host model and the bound checker.
`timescale 1ns/1ps
module tws_slave_tb_top;
    logic clock = 1'b0, rst = 1'b1, pin = 1'b0, ovr_en = 1'b0;
    logic [7:0] ovr = 8'h00;
    wire scl, sda_low, oe, out, reg_wr, reg_rd, busy, sel, rdm;
    wire [15:0] reg_addr;
    wire [7:0] reg_wdata;
    wire sda_line = (oe ? out : 1'b1) & !sda_low;
    wire [7:0] reg_rdata = reg_addr[7:0] ^ reg_addr[15:8] ^ 8'h5a;
    int err_total = 0, checks = 0, cyc = 0;
    logic [23:0] wq[$];
    logic [15:0] rq[$];
    logic [15:0] ptr = 16'h0000;
    initial forever #20 clock = !clock;
    tws_host_model host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    tws_slave dut (.clock(clock), .rst(rst), .serial_clock_line_in(scl), .serial_data_line_in(sda_line),
        .serial_data_line_out(out), .serial_data_line_oe(oe), .address_select_pin(pin),
        .addr_override_en(ovr_en), .addr_override(ovr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_busy(busy), .selected(sel), .read_mode(rdm));
    function automatic logic [7:0] model_rd(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(negedge clock) begin
        if (reg_wr === 1'b1) begin
            if (wq.size() == 0) chk({reg_addr, reg_wdata}, 24'hxxxxxx);
            else chk({reg_addr, reg_wdata}, wq.pop_front());
        end
        if (reg_rd === 1'b1) begin
            if (rq.size() == 0) chk({reg_addr, 8'h00}, 24'hxxxxxx);
            else chk({reg_addr, 8'h00}, {rq.pop_front(), 8'h00});
        end
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report;
        end
    end
    // Every byte must see the address ack outcome, also after a mismatch
    task wr_seq(input logic [7:0] dev, input logic [15:0] a, input int n, input logic e);
        logic ack;
        logic [7:0] d;
        host.start_cond;
        host.wr_byte(dev, ack);
        chk({23'h0, ack}, {23'h0, e});
        chk({21'h0, busy, sel, rdm & e}, {21'h0, 1'b1, e, 1'b0});
        host.wr_byte(a[15:8], ack);
        chk({23'h0, ack}, {23'h0, e});
        host.wr_byte(a[7:0], ack);
        chk({23'h0, ack}, {23'h0, e});
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (e) wq.push_back({a + 16'(i), d});
            host.wr_byte(d, ack);
            chk({23'h0, ack}, {23'h0, e});
        end
        if (e) ptr = a + 16'(n);
        host.stop_cond;
        chk({22'h0, busy, sel}, 24'h0);
    endtask
    task rd_seq(input logic set_addr, input logic [15:0] a, input int n);
        logic ack;
        logic [7:0] d;
        host.start_cond;
        if (set_addr) begin
            host.wr_byte(8'h90, ack);
            host.wr_byte(a[15:8], ack);
            host.wr_byte(a[7:0], ack);
            host.restart_cond;
            ptr = a;
        end
        for (int i = 0; i < n; i++) rq.push_back(ptr + 16'(i));
        host.wr_byte(8'h91, ack);
        chk({23'h0, ack}, 24'h1);
        chk({22'h0, sel, rdm}, 24'h3);
        for (int i = 0; i < n; i++) begin
            host.rd_byte(i < n - 1, d);
            chk({16'h0, d}, {16'h0, model_rd(ptr + 16'(i))});
        end
        ptr = ptr + 16'(n);
        host.stop_cond;
        chk({22'h0, busy, sel}, 24'h0);
    endtask
    task done(input int t);
        $display("test %0d done", t);
    endtask
    initial begin
        void'($urandom(7553));
        repeat (4) @(negedge clock);
        rst = 1'b0;
        repeat (8) @(negedge clock);
        wr_seq(8'h90, 16'h1234, 2, 1'b1);
        done(1);
        rd_seq(1'b1, 16'h12fe, 2);
        done(2);
        rd_seq(1'b0, 16'h0000, 3);
        done(3);
        wr_seq(8'hba, 16'h4000, 1, 1'b0);
        pin = 1'b1;
        wr_seq(8'hba, 16'h4000, 2, 1'b1);
        wr_seq(8'h90, 16'h4100, 1, 1'b0);
        pin = 1'b0;
        done(4);
        ovr = {7'($urandom_range(63, 1)), 1'b0};
        ovr_en = 1'b1;
        wr_seq(ovr, 16'h5555, 1, 1'b1);
        wr_seq(8'h90, 16'h5555, 1, 1'b0);
        ovr_en = 1'b0;
        done(5);
        for (int k = 0; k < 3; k++) wr_seq(8'h90, 16'($urandom), 1 + $urandom_range(2, 0), 1'b1);
        done(6);
        repeat (10) @(negedge clock);
        chk(24'(wq.size() + rq.size()), 24'h0);
        final_report;
    end
endmodule // tws_slave_tb_top
